// *** src/spi_port_pin_logic.v ***
// SPI port pin logic: master or slave engine with a receive FIFO.
// Functional notes
// - Master drives the serial clock and sets the rate; slave never drives it.
// - One serial clock cycle per bit transferred.
// - Serial clock toggles only during a word, idle otherwise.
// - As slave, clock edges are ignored while the select input is high.
// - Data launched on one clock edge, captured on the opposite edge.
// - Software sets clock polarity and phase, which choose the transfer format.
// - Select input is active low and acts as a chip select.
// - As master, a low select input flags a multimaster error.
// - Master drives MOSI; slave receives on MOSI.
// - Master receives on MISO; slave drives MISO.
// - With open drain selected, MISO is only ever pulled low.
// - At most one slave transmits on the shared MISO line.
// - With slave out disabled, the slave never drives MISO.
// - Clock, MOSI and MISO stay undriven in and after reset until configured.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"

// ----------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------
module spi_rx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
      if (reset) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // spi_rx_fifo

// ----------------------------------------------------------------
// Port engine
// ----------------------------------------------------------------
module spi_port_pin_logic #(
   parameter WORD_BITS = `SPI_WORD_BITS,
   parameter FIFO_DEPTH = `SPI_FIFO_DEPTH
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset,
   // Control register bits
   input wire [5:0] spi_control_register,
   input wire [7:0] clock_divide,
   // Transmit word
   input wire tx_valid,
   input wire [WORD_BITS-1:0] tx_data,
   output reg tx_ready,
   // Received words
   output reg rx_valid,
   input wire rx_ready,
   output reg [WORD_BITS-1:0] rx_data,
   // Status
   output reg busy,
   output reg multimaster_error,
   input wire multimaster_error_clear,
   output reg rx_overrun,
   // Serial clock pin
   input wire serial_clock_pin_in,
   output reg serial_clock_pin_out,
   output reg serial_clock_pin_oe_n,
   // Slave select pin
   input wire slave_select_input_n,
   // MOSI pin
   input wire mosi_in,
   output reg mosi_out,
   output reg mosi_oe_n,
   // MISO pin
   input wire miso_in,
   output reg miso_out,
   output reg miso_oe_n
);
   localparam BW = 5;
   localparam IDLE = 2'b00;
   localparam RUN = 2'b01;
   localparam DONE = 2'b10;

   wire cpol = spi_control_register[`SPI_CTRL_CPOL];
   wire cpha = spi_control_register[`SPI_CTRL_CPHA];
   wire is_master = spi_control_register[`SPI_CTRL_MASTER];
   wire enable = spi_control_register[`SPI_CTRL_ENABLE];
   wire open_drain_select = spi_control_register[`SPI_CTRL_OPEN_DRAIN];
   wire slave_out_disable = spi_control_register[`SPI_CTRL_SLAVE_OUT_DISABLE];

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [1:0] sck_sync;
   reg [1:0] ss_sync;
   reg [1:0] mosi_sync;
   reg [1:0] miso_sync;
   reg sck_prev;
   always @(posedge sys_clk) begin
      if (reset) begin
         // The pins idle high on their pull-ups, so no false edge follows reset.
         sck_sync <= 2'b11;
         ss_sync <= 2'b11;
         mosi_sync <= 2'b11;
         miso_sync <= 2'b11;
         sck_prev <= 1'b1;
      end else begin
         sck_sync <= {sck_sync[0], serial_clock_pin_in};
         ss_sync <= {ss_sync[0], slave_select_input_n};
         mosi_sync <= {mosi_sync[0], mosi_in};
         miso_sync <= {miso_sync[0], miso_in};
         sck_prev <= sck_sync[1];
      end
   end
   // With polarity zero the leading edge rises; polarity one flips the sense.
   wire sck_lead = (sck_sync[1] != sck_prev) && ((sck_sync[1] ^ cpol) == 1'b1);
   wire sck_trail = (sck_sync[1] != sck_prev) && ((sck_sync[1] ^ cpol) == 1'b0);
   wire selected = !ss_sync[1];

   // ----------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------
   reg [1:0] state;
   reg [WORD_BITS-1:0] shifter;
   reg [BW-1:0] bit_count;
   reg [7:0] div_count;
   reg phase;
   reg sample_bit;
   reg miso_bit;
   reg [WORD_BITS-1:0] done_word;
   reg done_pulse;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [WORD_BITS-1:0] fifo_out_data;
   wire tick = (div_count == 8'h00);
   wire out_bit = shifter[WORD_BITS-1];

   always @(posedge sys_clk) begin
      if (reset || !enable) begin
         state <= IDLE;
         shifter <= {WORD_BITS{1'b0}};
         bit_count <= {BW{1'b0}};
         div_count <= 8'h00;
         phase <= 1'b0;
         sample_bit <= 1'b0;
         done_word <= {WORD_BITS{1'b0}};
         done_pulse <= 1'b0;
         tx_ready <= 1'b0;
         busy <= 1'b0;
         serial_clock_pin_out <= 1'b0;
         mosi_out <= 1'b1;
         miso_bit <= 1'b1;
      end else begin
         done_pulse <= 1'b0;
         tx_ready <= 1'b0;
         if (is_master) begin
            if (state == IDLE) begin
               serial_clock_pin_out <= cpol;
            end
            case (state)
               IDLE: begin
                  busy <= 1'b0;
                  if (tx_valid && !tx_ready) begin
                     tx_ready <= 1'b1;
                     shifter <= tx_data;
                     bit_count <= WORD_BITS[BW-1:0];
                     div_count <= (clock_divide == 8'h00) ? 8'h01 : clock_divide;
                     phase <= 1'b0;
                     busy <= 1'b1;
                     state <= RUN;
                     // Phase 0 launches first bit before the leading edge.
                     if (!cpha) begin
                        mosi_out <= tx_data[WORD_BITS-1];
                     end
                  end
               end
               RUN: begin
                  div_count <= tick ? ((clock_divide == 8'h00) ? 8'h01 : clock_divide)
                     : div_count - 8'h01;
                  if (tick) begin
                     phase <= !phase;
                     serial_clock_pin_out <= !serial_clock_pin_out;
                     if (!phase) begin
                        if (cpha) begin
                           mosi_out <= out_bit;
                        end else begin
                           sample_bit <= miso_sync[1];
                        end
                     end else begin
                        if (cpha) begin
                           shifter <= {shifter[WORD_BITS-2:0], miso_sync[1]};
                        end else begin
                           shifter <= {shifter[WORD_BITS-2:0], sample_bit};
                           mosi_out <= shifter[WORD_BITS-2];
                        end
                        bit_count <= bit_count - 1'b1;
                        if (bit_count == {{(BW-1){1'b0}}, 1'b1}) begin
                           state <= DONE;
                        end
                     end
                  end
               end
               DONE: begin
                  done_word <= shifter;
                  done_pulse <= 1'b1;
                  state <= IDLE;
               end
               default: begin
                  state <= IDLE;
               end
            endcase
         end else begin
            // Slave ignores the clock while deselected.
            if (!selected) begin
               state <= IDLE;
               bit_count <= {BW{1'b0}};
               busy <= 1'b0;
               if (tx_valid && !tx_ready) begin
                  tx_ready <= 1'b1;
                  shifter <= tx_data;
                  miso_bit <= tx_data[WORD_BITS-1];
               end
            end else begin
               busy <= 1'b1;
               // Capture on leading edge, launch on trailing (phase 0).
               if ((!cpha && sck_lead) || (cpha && sck_trail)) begin
                  shifter <= {shifter[WORD_BITS-2:0], mosi_sync[1]};
                  if (bit_count == WORD_BITS[BW-1:0] - 1'b1) begin
                     done_word <= {shifter[WORD_BITS-2:0], mosi_sync[1]};
                     done_pulse <= 1'b1;
                     bit_count <= {BW{1'b0}};
                  end else begin
                     bit_count <= bit_count + 1'b1;
                  end
               end
               if ((!cpha && sck_trail) || (cpha && sck_lead)) begin
                  miso_bit <= out_bit;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset || !enable) begin
         serial_clock_pin_oe_n <= 1'b1;
         mosi_oe_n <= 1'b1;
         miso_oe_n <= 1'b1;
         miso_out <= 1'b1;
      end else begin
         // Only the master drives the clock.
         serial_clock_pin_oe_n <= !is_master;
         mosi_oe_n <= !is_master;
         // Drive MISO only while selected as slave.
         miso_out <= miso_bit;
         miso_oe_n <= !(!is_master && selected && !slave_out_disable
            && (!open_drain_select || !miso_bit));
      end
   end

   // ----------------------------------------------------------------
   // Multimaster error and receive path
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         multimaster_error <= 1'b0;
         rx_overrun <= 1'b0;
      end else begin
         if (enable && is_master && selected) begin
            multimaster_error <= 1'b1;
         end else if (multimaster_error_clear) begin
            multimaster_error <= 1'b0;
         end
         if (done_pulse && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
         end else if (multimaster_error_clear) begin
            rx_overrun <= 1'b0;
         end
      end
   end

   spi_rx_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH),
      .AW(2)
   ) rx_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(done_pulse),
      .in_ready(fifo_in_ready),
      .in_data(done_word),
      .out_valid(fifo_out_valid),
      .out_ready(rx_ready && rx_valid),
      .out_data(fifo_out_data)
   );

   // Registered outputs lag the FIFO head by a cycle; a pop waits for refresh.
   always @(posedge sys_clk) begin
      if (reset) begin
         rx_valid <= 1'b0;
         rx_data <= {WORD_BITS{1'b0}};
      end else if (rx_ready && rx_valid) begin
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= fifo_out_valid;
         rx_data <= fifo_out_data;
      end
   end
endmodule // spi_port_pin_logic
`default_nettype wire

// *** pkg/spi_port_map.vh ***
// Constants for the SPI port pin logic.
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH
`define SPI_WORD_BITS 8
`define SPI_FIFO_DEPTH 4
`define SPI_DIV_DEFAULT 8'h04
`define SPI_CTRL_CPOL 0
`define SPI_CTRL_CPHA 1
`define SPI_CTRL_MASTER 2
`define SPI_CTRL_ENABLE 3
`define SPI_CTRL_OPEN_DRAIN 4
`define SPI_CTRL_SLAVE_OUT_DISABLE 5
`define SPI_CTRL_RESET 6'h00
`endif

// *** bench/spi_port_pin_logic_chk.sv ***
// Concurrent checks on the SPI port pin logic ports.
`timescale 1ns/1ps
`default_nettype none
module spi_port_chk (
   // Clock, reset and control
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [5:0] spi_control_register,
   // Status
   input wire logic busy,
   input wire logic multimaster_error,
   input wire logic multimaster_error_clear,
   // Pins
   input wire logic slave_select_input_n,
   input wire logic serial_clock_pin_out,
   input wire logic serial_clock_pin_oe_n,
   input wire logic mosi_oe_n,
   input wire logic miso_out,
   input wire logic miso_oe_n
);
   wire logic [5:0] ctl = spi_control_register;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Checked during reset too, so the reset term is not a disable here.
   chk_reset_released: assert property (disable iff (1'b0)
      reset |=> serial_clock_pin_oe_n && mosi_oe_n && miso_oe_n) else $error("pin driven in reset");
   chk_slave_no_clock: assert property (
      (!ctl[2])[*2] |-> serial_clock_pin_oe_n) else $error("slave drives clock");
   chk_idle_level: assert property (
      !busy && !$past(busy) && ctl == $past(ctl, 2) && !serial_clock_pin_oe_n
      |-> serial_clock_pin_out == ctl[0]) else $error("idle clock level wrong");
   chk_clock_gated: assert property (
      $changed(serial_clock_pin_out) && !serial_clock_pin_oe_n && ctl == $past(ctl, 2)
      |-> busy || $past(busy)) else $error("clock moved outside a word");
   chk_mm_raise: assert property (
      (ctl[3:2] == 2'b11 && !slave_select_input_n)[*4] |-> multimaster_error)
      else $error("multimaster error missed");
   chk_mm_sticky: assert property (
      multimaster_error && !multimaster_error_clear |=> multimaster_error)
      else $error("multimaster error dropped");
   chk_open_drain: assert property (
      ctl[4] && $past(ctl[4]) && !miso_oe_n |-> !miso_out) else $error("open drain drove high");
   chk_slave_out_off: assert property (
      (!ctl[2] && ctl[5])[*2] |-> miso_oe_n) else $error("disabled slave drove MISO");
endmodule // spi_port_chk
bind spi_port_pin_logic spi_port_chk chk (.sys_clk(sys_clk), .reset(reset),
   .spi_control_register(spi_control_register), .busy(busy),
   .multimaster_error(multimaster_error), .multimaster_error_clear(multimaster_error_clear),
   .slave_select_input_n(slave_select_input_n), .serial_clock_pin_out(serial_clock_pin_out),
   .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .mosi_oe_n(mosi_oe_n),
   .miso_out(miso_out), .miso_oe_n(miso_oe_n));
`default_nettype wire

// *** bench/spi_far_slave.sv ***
// Behavioural SPI slave on the far side of the master port.
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
   // Pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   output logic miso_val,
   output logic miso_oe_n,
   // Format and data
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_word,
   output logic [7:0] rx_word
);
   logic [7:0] shreg;
   logic first;
   always @(negedge sel_n) begin
      shreg = tx_word;
      first = 1'b1;
   end
   // drive only MISO, only while selected
   assign miso_oe_n = sel_n;
   assign miso_val = shreg[7];
   // sample and launch on opposite edges
   always @(sck) begin
      if (!sel_n && sck == !(cpol ^ cpha)) begin
         rx_word = {rx_word[6:0], mosi};
      end else if (!sel_n) begin
         if (!(cpha && first)) shreg = {shreg[6:0], 1'b0};
         first = 1'b0;
      end
   end
endmodule // spi_far_slave
`default_nettype wire

// *** bench/test_spi_port_pin_logic.sv ***
// Self-checking testbench for the SPI port pin logic.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_map.vh"
module test_spi_port_pin_logic;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] ctl = 6'h00;
   logic tx_valid = 1'b0, rx_ready = 1'b0, mm_clr = 1'b0, ss_n = 1'b1;
   logic b_en = 1'b0, b_sck = 1'b1, b_mosi = 1'b1, f_sel_n = 1'b1;
   logic [7:0] tx_data = 8'h00, f_tx = 8'h00;
   logic [5:0] modes [6] = '{6'h08, 6'h0b, 6'h1a, 6'h29, 6'h09, 6'h08};
   wire logic tx_ready, rx_valid, busy, mm_err, rx_overrun, sck_o, sck_oe_n;
   wire logic mosi_o, mosi_oe_n, miso_o, miso_oe_n, f_miso, f_oe_n;
   wire logic [7:0] rx_data, f_rx;
   int n_fail = 0, tests_run = 0, n_edges = 0;
   // All three pins have pull-ups, so a released pin reads high.
   wire logic sck_w = !sck_oe_n ? sck_o : (b_en ? b_sck : 1'b1);
   wire logic mosi_w = !mosi_oe_n ? mosi_o : (b_en ? b_mosi : 1'b1);
   wire logic miso_w = !miso_oe_n ? miso_o : (!f_oe_n ? f_miso : 1'b1);
   spi_port_pin_logic dut (.sys_clk(sys_clk), .reset(reset), .spi_control_register(ctl),
      .clock_divide(`SPI_DIV_DEFAULT), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .busy(busy), .multimaster_error(mm_err), .multimaster_error_clear(mm_clr),
      .rx_overrun(rx_overrun), .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
      .serial_clock_pin_oe_n(sck_oe_n), .slave_select_input_n(ss_n), .mosi_in(mosi_w),
      .mosi_out(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_o),
      .miso_oe_n(miso_oe_n));
   spi_far_slave far (.sck(sck_w), .mosi(mosi_w), .sel_n(f_sel_n), .miso_val(f_miso),
      .miso_oe_n(f_oe_n), .cpol(ctl[0]), .cpha(ctl[1]), .tx_word(f_tx), .rx_word(f_rx));
   initial begin
      forever #20 sys_clk = !sys_clk;
   end
   always @(sck_w) n_edges++;
   task automatic tally_and_finish;
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic await(input int which);
      for (int i = 0; i < 2000; i++) begin
         tick(1);
         if (which == 0 ? tx_ready : (which == 1 ? rx_valid : mm_err)) return;
      end
      n_fail++;
      tally_and_finish();
   endtask
   task automatic send(input logic [7:0] w);
      tx_data = w;
      tx_valid = 1'b1;
      await(0);
      tx_valid = 1'b0;
   endtask
   task automatic pop(input logic [7:0] want);
      await(1);
      check("rx_data", rx_data, want);
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
   endtask
   // The bench plays an outside master; MISO is read just before the middle edge.
   task automatic drive_word(input logic [7:0] m, output logic [7:0] s);
      ss_n = 1'b0;
      #160;
      for (int k = 7; k >= 0; k--) begin
         if (ctl[1]) b_sck = !b_sck;
         b_mosi = m[k];
         #160;
         s[k] = miso_w;
         b_sck = !b_sck;
         #160;
         if (!ctl[1]) b_sck = !b_sck;
      end
      #160 ss_n = 1'b1;
   endtask
   initial begin
      logic [7:0] got;
      tick(8);
      reset = 1'b0;
      tick(2);
      check("pin enables", {5'h00, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
      ctl = 6'h0c;
      tick(6);
      check("mm idle", {7'h00, mm_err}, 8'h00);
      ss_n = 1'b0;
      await(2);
      tick(2);
      ss_n = 1'b1;
      tick(4);
      check("mm sticky", {7'h00, mm_err}, 8'h01);
      mm_clr = 1'b1;
      tick(1);
      mm_clr = 1'b0;
      tick(1);
      check("mm cleared", {7'h00, mm_err}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         ctl = 6'h0c | i[5:0];
         f_tx = 8'ha5 ^ i[7:0];
         tick(4);
         check("idle clock", {7'h00, sck_w}, {7'h00, i[0]});
         f_sel_n = 1'b0;
         n_edges = 0;
         send(8'h3c + i[7:0]);
         pop(8'ha5 ^ i[7:0]);
         check("far rx", f_rx, 8'h3c + i[7:0]);
         check("clock edges", n_edges[7:0], 8'h10);
         f_sel_n = 1'b1;
      end
      ctl = 6'h08;
      b_en = 1'b1;
      b_sck = 1'b0;
      tick(4);
      repeat (16) #160 b_sck = !b_sck;
      tick(8);
      check("ignored clocks", {7'h00, rx_valid}, 8'h00);
      // Six words with no pops: more than the buffer holds.
      for (int i = 0; i < 6; i++) begin
         ctl = modes[i];
         b_sck = modes[i][0];
         tick(4);
         send(8'hc0 | i[7:0]);
         drive_word(8'h51 + i[7:0], got);
         check("slave miso", got, modes[i][5] ? 8'hff : 8'hc0 | i[7:0]);
         tick(8);
      end
      check("overrun", {7'h00, rx_overrun}, 8'h01);
      for (int i = 0; i < 4; i++) pop(8'h51 + i[7:0]);
      rx_ready = 1'b1;
      mm_clr = 1'b1;
      tick(8);
      rx_ready = 1'b0;
      mm_clr = 1'b0;
      tick(1);
      check("drained", {6'h00, rx_valid, rx_overrun}, 8'h00);
      tally_and_finish();
   end
endmodule // test_spi_port_pin_logic
`default_nettype wire
